// ---- dv/icc_pin_src.sv ----
// Purpose: external signal source on the capture pin
// Assumes: hold of 2 or more gives levels of 3 or more clocks
// Notes: pin rests at its last level between bursts
`timescale 1ns/100ps
`default_nettype none
module icc_pin_src (
  input wire logic aclk, // clock
  input wire logic start, // begin burst
  input wire logic [7:0] edges, // toggles to make
  input wire logic [3:0] hold, // extra cycles per level
  output logic pin, // capture pin
  output logic busy // burst running
);
  logic [7:0] left;
  logic [3:0] cnt;
  initial begin
    pin = 1'h0;
    busy = 1'h0;
  end
  always @(posedge aclk) begin
    if (start && !busy) begin
      left <= edges;
      cnt <= hold;
      busy <= edges != 8'h00;
    end else if (busy && cnt == 4'h0) begin
      pin <= !pin;
      left <= left - 8'h01;
      cnt <= hold;
      busy <= left != 8'h01;
    end else if (busy) begin
      cnt <= cnt - 4'h1;
    end
  end
endmodule : icc_pin_src
`default_nettype wire

// ---- dv/icc_props.sv ----
// Purpose: port-level checks for the capture channel
// Assumes: master offers write address and data together, full strobes
// Notes: control shadow tracks only full-word writes
`timescale 1ns/100ps
`default_nettype none
module icc_props (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset, low
  input wire logic irq, // interrupt
  input wire logic [11:0] s_axi_awaddr, // aw addr
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic [31:0] s_axi_wdata, // w data
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic [11:0] s_axi_araddr, // ar addr
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata, // r data
  input wire logic [1:0] s_axi_rresp, // r resp
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready // r ready
);
  logic rd_ctl_r, rd_ok_r, rd_bad_r;
  logic [15:0] ctl_r;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {rd_ctl_r, rd_ok_r, rd_bad_r} <= 3'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rd_ctl_r <= s_axi_araddr == 12'h000;
      rd_ok_r <= s_axi_araddr <= 12'h008 && s_axi_araddr[1:0] == 2'h0;
      rd_bad_r <= s_axi_araddr >= 12'h018;
    end
  end
  // shadow of writable control bits; hardware status bits are left out
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_r <= 16'h0000;
    end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                 && s_axi_awaddr == 12'h000) begin
      ctl_r <= s_axi_wdata[15:0] & 16'h20E7;
    end
  end
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  rresp_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response not held");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid) else $error("write answer late");
  ctrl_zero_bits_a: assert property (
    s_axi_rvalid && rd_ctl_r |-> s_axi_rdata[15:14] == 2'h0 && s_axi_rdata[12:8] == 5'h00)
    else $error("unimplemented control bits not zero");
  ctrl_readback_a: assert property (
    s_axi_rvalid && rd_ctl_r |-> (s_axi_rdata[15:0] & 16'h20E7) == ctl_r)
    else $error("control readback differs");
  ov_needs_data_a: assert property (
    s_axi_rvalid && rd_ctl_r && s_axi_rdata[4] |-> s_axi_rdata[3])
    else $error("overflow with empty buffer");
  map_resp_a: assert property (s_axi_rvalid && (rd_ok_r || rd_bad_r)
    |-> s_axi_rresp == {rd_bad_r, 1'h0}) else $error("read response code wrong");
  irq_reset_a: assert property ($past(!aresetn) |-> !irq)
    else $error("interrupt high after reset");
endmodule : icc_props
bind icc_top icc_props u_props (.*);
`default_nettype wire

// ---- dv/test_input_capture_control.sv ----
// Purpose: self-checking bench for the capture channel
// Assumes: reads answered in order, one at a time
// Notes: timer values stay fixed during a burst, so buffer order is not resolved
`timescale 1ns/100ps
`default_nettype none
module test_input_capture_control;
  import icc_pkg::*;
  typedef struct packed {logic [1:0] r; logic [31:0] m; logic [31:0] d;} icc_exp_t;
  logic aclk = 1'h0, aresetn = 1'h0, cpu_idle = 1'h0, cpu_sleep = 1'h0;
  logic capture_input_pin, irq, busy, go = 1'h0;
  icc_timers_t timers = '0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, seed = 32'h00000055;
  logic [3:0] s_axi_wstrb = 4'hF, n_hold = 4'h2;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] n_tg = 8'h00;
  logic [2:0] ien = 3'h7;
  icc_exp_t q[$];
  icc_exp_t e;
  int mismatches = 0, checks = 0, cyc = 0;
  int tg[8] = '{8, 2, 4, 4, 8, 32, 8, 8};
  int cp[8] = '{0, 2, 2, 2, 1, 1, 0, 0};
  icc_top DUT (.*);
  icc_pin_src src (.aclk(aclk), .start(go), .edges(n_tg), .hold(n_hold),
    .pin(capture_input_pin), .busy(busy));
  initial forever #5 aclk = ~aclk;
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  function automatic void chk(string n, logic [31:0] x, logic [31:0] g);
    checks++;
    if (g !== x) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", n, x, g);
    end
  endfunction : chk
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      mismatches++;
      report_and_stop();
    end
  end
  // results are compared in the cycle the read answer is accepted
  always @(negedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      e = q.pop_front();
      chk("rresp", {30'h0, e.r}, {30'h0, s_axi_rresp});
      chk("rdata", e.d, s_axi_rdata & e.m);
    end
  end
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    forever begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      if (tb) begin
        chk("bresp", {30'h0, ICC_RESP_OK}, {30'h0, s_axi_bresp});
        s_axi_bready <= 1'h1;
        @(posedge aclk);
        s_axi_bready <= 1'h0;
        break;
      end
    end
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m,
                    input logic [1:0] r);
    logic ta, tr;
    q.push_back('{r, m, d & m});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    forever begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'h0;
      if (tr) begin
        s_axi_rready <= 1'h1;
        @(posedge aclk);
        s_axi_rready <= 1'h0;
        break;
      end
    end
  endtask : rd
  task automatic run(input logic [15:0] c, input int n, input int caps, input logic [2:0] ist);
    logic [31:0] t;
    t = xs();
    timers <= icc_timers_t'(t);
    wr(ICC_OFF_CTRL, {16'h0000, c});
    go <= 1'h1;
    n_tg <= 8'(n);
    n_hold <= 4'(2 + xs() % 4);
    @(posedge aclk);
    go <= 1'h0;
    @(negedge aclk);
    while (busy) @(negedge aclk);
    repeat (8) @(posedge aclk);
    rd(ICC_OFF_IST, {29'h0, ist}, 32'h00000007, ICC_RESP_OK);
    @(negedge aclk);
    chk("irq", {31'h0, |(ist & ien)}, {31'h0, irq});
    rd(ICC_OFF_CTRL, (c & ICC_CTRL_WMASK) | (caps > 4 ? 16'h10 : 16'h0)
       | (caps > 0 ? 16'h8 : 16'h0), 32'h0000FFFF, ICC_RESP_OK);
    for (int i = 0; i < caps && i < ICC_DEPTH; i++) begin
      rd(ICC_OFF_BUF, c[ICC_B_TMR] ? t[31:16] : t[15:0], 32'h0000FFFF, ICC_RESP_OK);
    end
    rd(ICC_OFF_CTRL, c & ICC_CTRL_WMASK, 32'h0000FFFF, ICC_RESP_OK);
    wr(ICC_OFF_ICLR, 32'h00000007);
  endtask : run
  initial begin
    logic [15:0] c;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    rd(ICC_OFF_CTRL, 32'h0, 32'h0000FFFF, ICC_RESP_OK);
    rd(12'h018, 32'h0, 32'hFFFFFFFF, ICC_RESP_SLVERR);
    wr(ICC_OFF_IEN, 32'h00000007);
    rd(ICC_OFF_IEN, 32'h00000007, 32'hFFFFFFFF, ICC_RESP_OK);
    run(16'hFFFF, 0, 0, 3'h0);
    for (int m = 0; m < 8; m++) begin
      c = {8'h00, xs() % 2 == 1, m == 1 ? 2'h3 : 2'h0, 2'h0, 3'(m)};
      run(c, tg[m], cp[m], {2'h0, cp[m] > 0});
    end
    for (int k = 1; k < 4; k++) begin
      c = 16'h0003 | 16'(k << ICC_B_ICI);
      run(c, 2 * k, k, 3'h0);
      run(c, 2, 1, 3'h1);
    end
    run(16'h0001, 10, 10, 3'h3);
    cpu_idle <= 1'h1;
    run(16'h2003, 2, 0, 3'h0);
    run(16'h0003, 2, 1, 3'h1);
    cpu_idle <= 1'h0;
    cpu_sleep <= 1'h1;
    run(16'h0003, 2, 0, 3'h0);
    rd(ICC_OFF_PWR, 32'h00000002, 32'hFFFFFFFF, ICC_RESP_OK);
    ien = 3'h3;
    wr(ICC_OFF_IEN, 32'h00000003);
    run(16'h0007, 2, 0, 3'h4);
    ien = 3'h7;
    wr(ICC_OFF_IEN, 32'h00000007);
    run(16'h0007, 2, 0, 3'h4);
    cpu_sleep <= 1'h0;
    report_and_stop();
  end
endmodule : test_input_capture_control
`default_nettype wire

// ---- hdl/icc_fifo.sv ----
// Purpose: capture value buffer, first in first out
// Assumes: a push into a full buffer is dropped unless a pop frees room
// Notes: pop and push in one cycle are allowed
`timescale 1ns/100ps
`default_nettype none
module icc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, low
  input wire logic push, // write strobe
  input wire logic [WIDTH-1:0] din, // write data
  input wire logic pop, // read strobe
  output logic [WIDTH-1:0] dout, // head entry
  output logic empty, // no entries
  output logic full // all entries used
);
  import icc_pkg::*;
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_chk
    $error("icc_fifo: DEPTH must be power of 2");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r, rp_r;
  logic [AW:0] cnt_r;
  logic do_pop, do_push;
  assign do_pop = pop && !empty;
  assign do_push = push && (!full || do_pop);
  assign empty = (cnt_r == '0);
  assign full = (cnt_r == (AW+1)'(DEPTH));
  assign dout = mem[rp_r];
  always_ff @(posedge aclk) begin
    if (do_push) begin
      mem[wp_r] <= din;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (do_push) wp_r <= wp_r + 1'b1;
      if (do_pop) rp_r <= rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule : icc_fifo
`default_nettype wire

// ---- hdl/icc_pkg.sv ----
// Purpose: shared constants and types for the input capture control block
// Assumes: 32-bit AXI4-Lite register bus, 16-bit timer counts
// Notes: offsets are byte addresses
package icc_pkg;
  localparam int ICC_TW = 16;
  localparam logic [11:0] ICC_OFF_CTRL = 12'h000;
  localparam logic [11:0] ICC_OFF_BUF = 12'h004;
  localparam logic [11:0] ICC_OFF_IST = 12'h008;
  localparam logic [11:0] ICC_OFF_IEN = 12'h00C;
  localparam logic [11:0] ICC_OFF_ICLR = 12'h010;
  localparam logic [11:0] ICC_OFF_PWR = 12'h014;
  localparam int ICC_B_SIDL = 13;
  localparam int ICC_B_TMR = 7;
  localparam int ICC_B_ICI = 5;
  localparam int ICC_B_OV = 4;
  localparam int ICC_B_BNE = 3;
  localparam int ICC_B_MODE = 0;
  localparam logic [15:0] ICC_CTRL_RST = 16'h0000;
  localparam logic [15:0] ICC_CTRL_WMASK = 16'h20E7;
  localparam logic [2:0] ICC_IST_RST = 3'h0;
  localparam int ICC_IS_CAP = 0;
  localparam int ICC_IS_OV = 1;
  localparam int ICC_IS_WAKE = 2;
  localparam logic [4:0] ICC_PRE4 = 5'h04;
  localparam logic [4:0] ICC_PRE16 = 5'h10;
  localparam int ICC_DEPTH = 4;
  localparam logic [1:0] ICC_RESP_OK = 2'h0;
  localparam logic [1:0] ICC_RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    ICC_M_OFF = 3'h0, ICC_M_BOTH = 3'h1, ICC_M_FALL = 3'h2, ICC_M_RISE = 3'h3,
    ICC_M_RISE4 = 3'h4, ICC_M_RISE16 = 3'h5, ICC_M_UNUSED = 3'h6, ICC_M_WAKE = 3'h7
  } icc_mode_t;
  typedef struct packed {
    logic idle_stop_select;
    logic timer_source_select;
    logic [1:0] captures_per_interrupt;
    icc_mode_t capture_mode_field;
  } icc_ctrl_t;
  typedef struct packed {
    logic [ICC_TW-1:0] second_timer_count;
    logic [ICC_TW-1:0] third_timer_count;
  } icc_timers_t;
endpackage : icc_pkg

// ---- hdl/icc_sync.sv ----
// Purpose: three-stage synchroniser with agreement filter for the capture pin
// Assumes: pin is asynchronous to aclk
// Notes: output changes only when stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module icc_sync (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, low
  input wire logic pin_raw, // raw pin
  output logic level // filtered level
);
  import icc_pkg::*;
  logic s1_r, s2_r, s3_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      level <= 1'b0;
    end else begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level <= s3_r;
      end
    end
  end
endmodule : icc_sync
`default_nettype wire

// ---- hdl/icc_top.sv ----
// Purpose: one input capture channel with AXI4-Lite registers
// Assumes: timers and cpu power state come from outside on aclk
// Notes: capture buffer read pops the head entry
// Functional notes
// - idle-stop bit halts channel during idle
// - timer select one picks second timer
// - interrupt every first to fourth capture
// - read-only overflow status bit
// - read-only buffer not empty bit
// - status bits hardware cleared, reset zero
// - mode 111 wake on rising edge only
// - mode 110 behaves as disabled
// - mode 101 captures every sixteenth rise
// - mode 100 captures every fourth rise
// - mode 011 captures every rising edge
// - mode 010 captures every falling edge
// - mode 001 both edges, no decimation
// - mode 000 switches channel off
// - unimplemented control bits read zero
// - four-entry first-in first-out buffer
`timescale 1ns/100ps
`default_nettype none
module icc_top #(
  parameter int DEPTH = 4
) (
  input wire logic aclk, // clock 100 MHz
  input wire logic aresetn, // sync reset, low
  input wire logic capture_input_pin, // external capture pin
  input wire icc_pkg::icc_timers_t timers, // timer counts
  input wire logic cpu_idle, // cpu in idle
  input wire logic cpu_sleep, // cpu in sleep
  output logic irq, // interrupt level
  input wire logic [11:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [11:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data ready
);
  import icc_pkg::*;
  // only a four-entry buffer matches the register layout
  if (DEPTH != ICC_DEPTH) begin : g_depth_chk
    $error("icc_top: buffer depth must be four");
  end

  icc_ctrl_t ctrl_r;
  logic ov_r;
  logic [2:0] ist_r, ien_r;
  logic [1:0] icnt_r;
  logic [4:0] pre_r;
  icc_mode_t mode_q_r;
  logic lvl, lvl_q_r;
  logic rise, fall, halted, active, mode_chg;
  logic cap_edge, cap_ev, wake_ev, irq_ev;
  logic [ICC_TW-1:0] cap_val, fifo_dout;
  logic fifo_empty, fifo_full, fifo_pop;

  // pin is asynchronous; filtered before any edge is detected
  icc_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_raw(capture_input_pin),
    .level(lvl)
  );

  // reset value matches the idle-low pin, so no false edge follows reset
  always_ff @(posedge aclk) begin
    if (!aresetn) lvl_q_r <= 1'b0;
    else lvl_q_r <= lvl;
  end
  assign rise = lvl && !lvl_q_r;
  assign fall = !lvl && lvl_q_r;

  // sleep always halts capture; idle halts only with the stop bit
  assign halted = cpu_sleep || (cpu_idle && ctrl_r.idle_stop_select);
  assign active = !halted;
  assign mode_chg = (ctrl_r.capture_mode_field != mode_q_r);

  // terminal counts of the two prescaled modes
  logic pre4_last, pre16_last;
  assign pre4_last = (pre_r == ICC_PRE4 - 5'h01);
  assign pre16_last = (pre_r == ICC_PRE16 - 5'h01);

  // edge qualification per mode
  always_comb begin
    cap_edge = 1'b0;
    unique case (ctrl_r.capture_mode_field)
      ICC_M_OFF: cap_edge = 1'b0;
      ICC_M_BOTH: cap_edge = rise || fall;
      ICC_M_FALL: cap_edge = fall;
      ICC_M_RISE: cap_edge = rise;
      ICC_M_RISE4: cap_edge = rise && pre4_last;
      ICC_M_RISE16: cap_edge = rise && pre16_last;
      ICC_M_UNUSED: cap_edge = 1'b0;
      ICC_M_WAKE: cap_edge = 1'b0;
    endcase
  end
  // the cycle of a mode change ignores edges, so none counts in two modes
  assign cap_ev = cap_edge && active && !mode_chg;
  // wake works in sleep or idle, ignoring every other control bit
  assign wake_ev = (ctrl_r.capture_mode_field == ICC_M_WAKE) && rise
    && (cpu_sleep || cpu_idle);

  // prescaler; mode change restarts it so counting begins fresh
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_r <= 5'h00;
      mode_q_r <= ICC_M_OFF;
    end else begin
      mode_q_r <= ctrl_r.capture_mode_field;
      if (mode_chg) begin
        pre_r <= 5'h00;
      end else if (rise && active) begin
        if (ctrl_r.capture_mode_field == ICC_M_RISE4) begin
          pre_r <= (pre_r >= ICC_PRE4 - 5'h01) ? 5'h00 : pre_r + 5'h01;
        end else if (ctrl_r.capture_mode_field == ICC_M_RISE16) begin
          pre_r <= (pre_r >= ICC_PRE16 - 5'h01) ? 5'h00 : pre_r + 5'h01;
        end
      end
    end
  end

  // timer chosen in the capture cycle itself, not latched earlier
  assign cap_val = ctrl_r.timer_source_select ? timers.second_timer_count
    : timers.third_timer_count;

  // a full buffer refuses the push unless a read frees room in that cycle
  icc_fifo #(
    .WIDTH(ICC_TW),
    .DEPTH(DEPTH)
  ) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .push(cap_ev),
    .din(cap_val),
    .pop(fifo_pop),
    .dout(fifo_dout),
    .empty(fifo_empty),
    .full(fifo_full)
  );

  // overflow: a capture into a full buffer is dropped and flagged
  // cleared by hardware once the buffer drains empty
  // the oldest four values are kept; newer ones are lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ov_r <= 1'b0;
    end else if (cap_ev && fifo_full && !fifo_pop) begin
      ov_r <= 1'b1;
    end else if (fifo_empty) begin
      ov_r <= 1'b0;
    end
  end

  // capture decimation counter
  // both-edge mode interrupts on every capture whatever the field holds
  always_ff @(posedge aclk) begin
    if (!aresetn || mode_chg) begin
      icnt_r <= 2'h0;
    end else if (cap_ev) begin
      if (ctrl_r.capture_mode_field == ICC_M_BOTH
          || icnt_r >= ctrl_r.captures_per_interrupt) begin
        icnt_r <= 2'h0;
      end else begin
        icnt_r <= icnt_r + 2'h1;
      end
    end
  end
  assign irq_ev = cap_ev && (ctrl_r.capture_mode_field == ICC_M_BOTH
    || icnt_r >= ctrl_r.captures_per_interrupt);

  // AXI4-Lite write path: address and data taken in either order
  logic aw_hold_r, w_hold_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_go;
  logic [2:0] iclr;
  logic [11:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;
  assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_r && !s_axi_bvalid;
  assign wa = aw_hold_r ? awaddr_r : s_axi_awaddr;
  assign wd = w_hold_r ? wdata_r : s_axi_wdata;
  assign ws = w_hold_r ? wstrb_r : s_axi_wstrb;
  assign wr_go = (aw_hold_r || (s_axi_awvalid && s_axi_awready))
    && (w_hold_r || (s_axi_wvalid && s_axi_wready));
  assign iclr = (wr_go && wa == ICC_OFF_ICLR && ws[0]) ? wd[2:0] : 3'h0;

  // unmapped words answer with an error response
  logic wr_hit;
  always_comb begin
    unique case (wa)
      ICC_OFF_CTRL, ICC_OFF_BUF, ICC_OFF_IST,
      ICC_OFF_IEN, ICC_OFF_ICLR, ICC_OFF_PWR: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // address channel holding stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      awaddr_r <= 12'h000;
    end else if (wr_go) begin
      aw_hold_r <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end
  end

  // data channel holding stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else if (wr_go) begin
      w_hold_r <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end
  end

  // write response; bvalid blocks new requests until it is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ICC_RESP_OK;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? ICC_RESP_OK : ICC_RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // control register: only implemented bits are writable
  // status bits of this word are hardware owned and ignore writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= '0;
    end else if (wr_go && wa == ICC_OFF_CTRL) begin
      if (ws[1]) ctrl_r.idle_stop_select <= wd[ICC_B_SIDL];
      if (ws[0]) begin
        ctrl_r.timer_source_select <= wd[ICC_B_TMR];
        ctrl_r.captures_per_interrupt <= wd[ICC_B_ICI +: 2];
        ctrl_r.capture_mode_field <= icc_mode_t'(wd[ICC_B_MODE +: 3]);
      end
    end
  end

  // enable register, same layout as the status word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ien_r <= ICC_IST_RST;
    end else if (wr_go && wa == ICC_OFF_IEN && ws[0]) begin
      ien_r <= wd[2:0];
    end
  end

  // sticky events, one flop per bit; a new event wins over a clear in the same cycle
  logic [2:0] ev;
  assign ev = {wake_ev, cap_ev && fifo_full && !fifo_pop, irq_ev};
  for (genvar i = 0; i < 3; i++) begin : g_ist
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        ist_r[i] <= ICC_IST_RST[i];
      end else if (ev[i]) begin
        ist_r[i] <= 1'b1;
      end else if (iclr[i]) begin
        ist_r[i] <= 1'b0;
      end
    end
  end
  // level interrupt; stays up until software clears the status bit or its enable bit
  assign irq = |(ist_r & ien_r);

  // read path
  // one read under way at a time; arready waits until the answer is taken
  logic rd_take;
  logic [31:0] rd_val;
  logic [15:0] ctrl_view;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_take = s_axi_arvalid && s_axi_arready;
  logic rd_hit;
  always_comb begin
    unique case (s_axi_araddr)
      ICC_OFF_CTRL, ICC_OFF_BUF, ICC_OFF_IST,
      ICC_OFF_IEN, ICC_OFF_ICLR, ICC_OFF_PWR: rd_hit = 1'b1;
      default: rd_hit = 1'b0;
    endcase
  end
  // control view assembled bit by bit; unlisted bits stay zero
  always_comb begin
    ctrl_view = 16'h0000;
    ctrl_view[ICC_B_SIDL] = ctrl_r.idle_stop_select;
    ctrl_view[ICC_B_TMR] = ctrl_r.timer_source_select;
    ctrl_view[ICC_B_ICI +: 2] = ctrl_r.captures_per_interrupt;
    ctrl_view[ICC_B_OV] = ov_r;
    ctrl_view[ICC_B_BNE] = !fifo_empty;
    ctrl_view[ICC_B_MODE +: 3] = ctrl_r.capture_mode_field;
  end
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (s_axi_araddr)
      ICC_OFF_CTRL: rd_val = {16'h0000, ctrl_view};
      // head entry as it stands before the pop
      ICC_OFF_BUF: rd_val = {16'h0000, fifo_dout};
      ICC_OFF_IST: rd_val = {29'h0, ist_r};
      ICC_OFF_IEN: rd_val = {29'h0, ien_r};
      // lets software see the cpu state the channel reacts to
      ICC_OFF_PWR: rd_val = {30'h0, cpu_sleep, cpu_idle};
      default: rd_val = 32'h0000_0000;
    endcase
  end
  // reading the buffer pops it; empty reads return the stale head
  assign fifo_pop = rd_take && s_axi_araddr == ICC_OFF_BUF;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ICC_RESP_OK;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_hit ? ICC_RESP_OK : ICC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : icc_top
`default_nettype wire
